// File: design/adc_mux_pkg.sv
// shared constants and carrier types for the converter input and reference selection block
package adc_mux_pkg;

  // ************************************************************
  // register map (printed offsets are word indices)
  // ************************************************************
  localparam logic [7:0] SEL_INDEX = 8'h07;      // selection register index
  localparam logic [7:0] STATUS_INDEX = 8'h08;   // selection status register index
  localparam logic [7:0] SEL_RESET = 8'h00;      // selection register reset value
  localparam int REF_MSB = 7;                    // reference field top bit
  localparam int REF_LSB = 6;                    // reference field low bit
  localparam int ST_PENDING = 0;                 // status: written value not yet applied
  localparam int ST_SETTLING = 1;                // status: differential stage settling
  localparam int ST_START_HOLD = 2;              // status: inside the no-start window

  // ************************************************************
  // reference field codes
  // ************************************************************
  localparam logic [1:0] REF_SUPPLY = 2'h0;      // supply used as reference
  localparam logic [1:0] REF_EXT_PIN = 2'h1;     // external pin, internal reference off
  localparam logic [1:0] REF_INTERNAL = 2'h2;    // internal 1.1v reference
  localparam logic [1:0] REF_INT_TO_PIN = 2'h3;  // reserved code: internal reference on the pin

  // ************************************************************
  // channel field codes
  // ************************************************************
  localparam logic [5:0] CH_SINGLE_LAST = 6'h07; // last single-ended input
  localparam logic [5:0] CH_GROUND = 6'h20;      // analog ground
  localparam logic [5:0] CH_BANDGAP = 6'h21;     // internal 1.1v source
  localparam logic [5:0] CH_TEMP = 6'h22;        // temperature channel
  localparam logic [5:0] CH_CAL_LAST = 6'h27;    // last offset calibration code
  localparam logic [3:0] DIFF_PAIR_BASE = 4'h4;  // code[4:1] of the first differential pair
  localparam logic [2:0] CAL_PIN_A = 3'h0;       // calibration input for code[2:1] == 1
  localparam logic [2:0] CAL_PIN_B = 3'h3;       // calibration input for code[2:1] == 2
  localparam logic [2:0] CAL_PIN_C = 3'h7;       // calibration input for code[2:1] == 3

  // {positive, negative} for the twelve normal pairs, entry 0 at the right
  localparam logic [11:0][5:0] DIFF_PAIRS = {
    6'h37, 6'h2e, 6'h25, 6'h1f, 6'h1e, 6'h1d,
    6'h1c, 6'h13, 6'h0b, 6'h0a, 6'h03, 6'h01};

  // ************************************************************
  // settling, counted in converter clock cycles
  // ************************************************************
  localparam logic [4:0] SETTLE_ADC_CYCLES = 5'h19;     // 25 cycles worst-case settling
  localparam logic [4:0] START_HOLD_ADC_CYCLES = 5'h0d; // 13 cycles with no start
  localparam logic [4:0] START_HOLD_LIMIT = 5'(SETTLE_ADC_CYCLES - START_HOLD_ADC_CYCLES);

  // ************************************************************
  // ahb-lite codes
  // ************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;   // nonsequential transfer
  localparam logic HRESP_OKAY = 1'b0;            // only response given

  // ************************************************************
  // carrier types
  // ************************************************************
  typedef enum logic [2:0] {
    KIND_SINGLE,
    KIND_DIFF,
    KIND_GROUND,
    KIND_BANDGAP,
    KIND_TEMP,
    KIND_OFFSET_CAL
  } chan_kind_t;

  typedef struct packed {
    chan_kind_t kind;    // what the multiplexer connects
    logic [2:0] pos;     // input on the positive side (or the single input)
    logic [2:0] neg;     // input on the negative side
    logic gain20;        // 20x gain stage selected
    logic temp_en;       // temperature sensor powered
  } chan_route_t;

  typedef struct packed {
    logic [1:0] ref_sel; // active reference code
    logic int_ref_on;    // internal reference powered
    logic ref_to_pin;    // internal reference driven onto the external pin
  } ref_route_t;

endpackage : adc_mux_pkg

// File: design/adc_chan_decode.sv
// channel code to multiplexer route decoder
`timescale 1ns/1ps
module adc_chan_decode
  import adc_mux_pkg::*;
(
  input wire logic [5:0] code,   // channel and gain code
  output chan_route_t route      // decoded route
);

  // ************************************************************
  // decode
  // ************************************************************
  logic [3:0] pair_idx; // pair table index, shared by normal and reversed codes
  logic [5:0] pair;     // {positive, negative} of the normal pair

  // combinational decode; the caller registers the result
  always_comb
  begin
    pair_idx = 4'(code[4:1] - DIFF_PAIR_BASE);
    pair = (pair_idx < 4'hc) ? DIFF_PAIRS[pair_idx] : 6'h00;
    route = '0;
    if (code <= CH_SINGLE_LAST)
    begin
      // single-ended inputs 0..7 on port a
      route.kind = KIND_SINGLE;
      route.pos = code[2:0];
    end
    else if (code == CH_GROUND)
      route.kind = KIND_GROUND;
    else if (code == CH_BANDGAP)
      route.kind = KIND_BANDGAP;
    else if (code == CH_TEMP)
    begin
      route.kind = KIND_TEMP;
      route.temp_en = 1'b1;
    end
    else if (code <= CH_CAL_LAST && code[5])
    begin
      // same pin on both sides so the stage offset can be measured
      route.kind = KIND_OFFSET_CAL;
      unique case (code[2:1])
        2'h1: route.pos = CAL_PIN_A;
        2'h2: route.pos = CAL_PIN_B;
        default: route.pos = CAL_PIN_C;
      endcase
      route.neg = route.pos;
      route.gain20 = code[0];
    end
    else
    begin
      // normal pairs and their reversals share one table
      route.kind = KIND_DIFF;
      route.gain20 = code[0];
      if (code[5])
      begin
        route.pos = pair[2:0];
        route.neg = pair[5:3];
      end
      else
      begin
        route.pos = pair[5:3];
        route.neg = pair[2:0];
      end
    end
  end

endmodule : adc_chan_decode

// File: design/adc_input_mux_select.sv
// converter input and reference selection register with ahb-lite access
// Contract
// - reference field: supply, pin, 1.1v, reserved
// - reference change waits for conversion end
// - code 11 drives internal reference to pin
// - channel change waits for conversion end
// - codes 0-7 pick single inputs 0-7
// - ground, bandgap, temperature with sensor enable
// - low channel bit selects 1x or 20x
// - top channel bit swaps pair polarity
// - differential, reversed and calibration code ranges
// - calibration ties one pin to both inputs
// - full differential pair decode
`timescale 1ns/1ps
module adc_input_mux_select
  import adc_mux_pkg::*;
(
  input wire logic core_clk,          // system clock, 25 mhz
  input wire logic rstn,              // synchronous reset, active low
  input wire logic hsel,              // ahb slave select
  input wire logic [31:0] haddr,      // ahb byte address
  input wire logic [1:0] htrans,      // ahb transfer type
  input wire logic hwrite,            // ahb write when high
  input wire logic [2:0] hsize,       // ahb size, word only
  input wire logic [31:0] hwdata,     // ahb write data
  input wire logic hready,            // ahb bus ready
  output logic hreadyout,             // ahb slave ready
  output logic hresp,                 // ahb response, always okay
  output logic [31:0] hrdata,         // ahb read data
  input wire logic conv_busy,         // conversion in progress
  input wire logic conv_done,         // conversion-done flag being set, one cycle
  input wire logic adc_tick,          // one pulse per converter clock cycle
  output chan_route_t chan_route,     // active multiplexer route
  output ref_route_t ref_route        // active reference route
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] sel;        // software copy of the selection register
    logic [7:0] act;        // selection the converter is using
    chan_route_t route;     // decoded active channel
    ref_route_t refr;       // decoded active reference
    logic [4:0] settle;     // converter cycles of settling left
    logic wr_pend;          // write data phase due this cycle
    logic [7:0] wr_idx;     // word index of that write
    logic [31:0] rdata;     // read data for the current data phase
    logic ready;            // slave ready
  } state_t;

  state_t s_r;              // registered state
  state_t s_nxt;            // next state
  chan_route_t dec_route;   // route decoded from the software copy

  // ************************************************************
  // helpers
  // ************************************************************
  // word index of a byte address; address bits above bit 9 are ignored, so offsets alias every 1024 bytes
  function automatic logic [7:0] word_idx(input logic [31:0] addr);
    word_idx = addr[9:2];
  endfunction : word_idx

  // reference code to reference routing
  function automatic ref_route_t ref_decode(input logic [1:0] code);
    ref_decode.ref_sel = code;
    ref_decode.int_ref_on = (code == REF_INTERNAL) || (code == REF_INT_TO_PIN);
    ref_decode.ref_to_pin = (code == REF_INT_TO_PIN);
  endfunction : ref_decode

  // true for routes that go through the gain stage
  function automatic logic is_diff(input chan_route_t r);
    is_diff = (r.kind == KIND_DIFF) || (r.kind == KIND_OFFSET_CAL);
  endfunction : is_diff

  // {positive, negative} table entry behind a differential code
  function automatic logic [5:0] pair_of(input logic [5:0] code);
    pair_of = DIFF_PAIRS[4'(code[4:1] - DIFF_PAIR_BASE)];
  endfunction : pair_of

  // ************************************************************
  // channel decoder
  // ************************************************************
  adc_chan_decode u_decode (
    .code (s_r.sel[5:0]),
    .route (dec_route)
  );

  // ************************************************************
  // next state
  // ************************************************************
  logic accept;          // address phase taken this cycle
  logic [7:0] sel_new;   // software copy after this cycle's write
  logic apply;           // converter idle or finishing, copy may be applied

  always_comb
  begin
    s_nxt = s_r;
    accept = hsel && (htrans == HTRANS_NONSEQ) && hready;
    apply = !conv_busy || conv_done;
    s_nxt.ready = 1'b1;
    // data phase of a write lands in the software copy only
    sel_new = s_r.sel;
    if (s_r.wr_pend && (s_r.wr_idx == SEL_INDEX))
      sel_new = hwdata[7:0];
    s_nxt.sel = sel_new;
    // address phase capture
    s_nxt.wr_pend = accept && hwrite;
    s_nxt.wr_idx = word_idx(haddr);
    if (accept && !hwrite)
    begin
      // forwarded value, so a read right behind a write sees it
      if (word_idx(haddr) == SEL_INDEX)
        s_nxt.rdata = {24'h000000, sel_new};
      else if (word_idx(haddr) == STATUS_INDEX)
      begin
        s_nxt.rdata = 32'h00000000;
        s_nxt.rdata[ST_PENDING] = (s_r.sel != s_r.act);
        s_nxt.rdata[ST_SETTLING] = (s_r.settle != 5'h00);
        s_nxt.rdata[ST_START_HOLD] = (s_r.settle > START_HOLD_LIMIT);
      end
      else
        s_nxt.rdata = 32'h00000000;                             // unmapped reads zero
    end
    // the converter keeps the old selection until its conversion ends
    if (apply)
    begin
      s_nxt.act = s_r.sel;
      s_nxt.route = dec_route;
      s_nxt.refr = ref_decode(s_r.sel[REF_MSB:REF_LSB]);
    end
    // settling tracker: software must honour it, hardware only reports it
    if (apply && (s_r.sel != s_r.act) && is_diff(dec_route))
      s_nxt.settle = SETTLE_ADC_CYCLES;
    else if (adc_tick && (s_r.settle != 5'h00))
      s_nxt.settle = 5'(s_r.settle - 5'h01);
  end

  // ************************************************************
  // state register
  // ************************************************************
  // synchronous reset to all zero: supply reference, single input 0
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ************************************************************
  // outputs, all but hresp straight from the state register; hresp is tied to okay
  // ************************************************************
  assign hreadyout = s_r.ready;
  assign hresp = HRESP_OKAY;
  assign hrdata = s_r.rdata;
  assign chan_route = s_r.route;
  assign ref_route = s_r.refr;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence sel_write_addr_s;
    hsel && (htrans == HTRANS_NONSEQ) && hready && hwrite && (word_idx(haddr) == SEL_INDEX);
  endsequence

  sequence sel_read_addr_s;
    hsel && (htrans == HTRANS_NONSEQ) && hready && !hwrite && (word_idx(haddr) == SEL_INDEX)
      && !(s_r.wr_pend && s_r.wr_idx == SEL_INDEX);
  endsequence

  sequence busy_window_s;
    conv_busy && !conv_done;
  endsequence

  hold_while_busy_a: assert property (@(posedge core_clk) disable iff (!rstn)
    busy_window_s |=> $stable(s_r.act) && $stable(ref_route))
    else $error("selection changed during a conversion");

  apply_when_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (!conv_busy || conv_done) |=> (s_r.act == $past(s_r.sel)))
    else $error("idle converter did not take the new selection");

  ref_pin_route_a: assert property (@(posedge core_clk) disable iff (!rstn)
    ref_route.ref_to_pin == (ref_route.ref_sel == REF_INT_TO_PIN))
    else $error("internal reference pin drive does not match code");

  ext_ref_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ref_route.ref_sel == REF_EXT_PIN) |-> !ref_route.int_ref_on)
    else $error("internal reference on with external pin selected");

  single_input_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.act[5:0] <= CH_SINGLE_LAST) && $stable(s_r.act) |->
      (chan_route.kind == KIND_SINGLE) && (chan_route.pos == s_r.act[2:0]))
    else $error("single-ended code routed wrongly");

  temp_enable_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $stable(s_r.act) |-> (chan_route.temp_en == (s_r.act[5:0] == CH_TEMP)))
    else $error("temperature sensor enable does not match channel");

  diff_gain_a: assert property (@(posedge core_clk) disable iff (!rstn)
    is_diff(chan_route) && $stable(s_r.act) |-> (chan_route.gain20 == s_r.act[0]))
    else $error("gain does not follow the low channel bit");

  cal_same_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (chan_route.kind == KIND_OFFSET_CAL) |-> (chan_route.pos == chan_route.neg))
    else $error("calibration route uses two different pins");

  sel_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sel_write_addr_s ##1 1'b1 |=> (s_r.sel == $past(hwdata[7:0])))
    else $error("written selection not stored");

  sel_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
    sel_read_addr_s |=> (hrdata == {24'h000000, $past(s_r.sel)}))
    else $error("read data does not show the selection register");

  // ************************************************************
  // route, settling and bus response assertions
  // ************************************************************
  // active pair route, once it is no longer changing
  sequence diff_live_s;
    $stable(s_r.act) && (chan_route.kind == KIND_DIFF);
  endsequence

  // a new differential or calibration code is being applied
  sequence diff_apply_s;
    (!conv_busy || conv_done) && (s_r.sel != s_r.act)
      && (s_r.sel[5:3] != 3'h0)
      && ((s_r.sel[5:0] < CH_GROUND) || (s_r.sel[5:0] > CH_TEMP));
  endsequence

  // reference route follows the top two bits
  ref_code_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $stable(s_r.act) |->
      (ref_route.ref_sel == s_r.act[REF_MSB:REF_LSB])
      && (ref_route.int_ref_on == s_r.act[REF_MSB]))
    else $error("reference route does not follow the code");

  // ground and bandgap differ only in the low bit
  gnd_bandgap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.act[5:1] == 5'h10) |->
      (chan_route.kind == (s_r.act[0] ? KIND_BANDGAP : KIND_GROUND)))
    else $error("ground or bandgap code routed wrongly");

  // every code outside 000xxx and 100xxx is a pair
  diff_kind_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.act[5:3] != 3'h0) && (s_r.act[5:3] != 3'h4) |->
      (chan_route.kind == KIND_DIFF))
    else $error("pair code not routed as a pair");

  // 100011 to 100111 are calibration selections
  cal_kind_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.act[5:3] == 3'h4) && (s_r.act[2:0] > 3'h2) |->
      (chan_route.kind == KIND_OFFSET_CAL))
    else $error("calibration code not routed for calibration");

  // calibration input picked by code bits 2:1
  cal_pins_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (chan_route.kind == KIND_OFFSET_CAL) |->
      (chan_route.pos == ((s_r.act[2:1] == 2'h1) ? CAL_PIN_A
        : ((s_r.act[2:1] == 2'h2) ? CAL_PIN_B : CAL_PIN_C))))
    else $error("calibration uses the wrong input");

  // first pair written out by hand, not from the table
  first_pair_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (s_r.act[5:1] == 5'h04) |->
      (chan_route.pos == 3'h0) && (chan_route.neg == 3'h1)
      && (chan_route.gain20 == s_r.act[0]))
    else $error("first pair decoded wrongly");

  // normal pairs follow the table
  pair_decode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    diff_live_s ##0 !s_r.act[5] |->
      ({chan_route.pos, chan_route.neg} == pair_of(s_r.act[5:0])))
    else $error("pair inputs do not match the table");

  // the top bit swaps the two sides of the same pair
  polarity_swap_a: assert property (@(posedge core_clk) disable iff (!rstn)
    diff_live_s ##0 s_r.act[5] |->
      ({chan_route.neg, chan_route.pos} == pair_of(s_r.act[5:0])))
    else $error("reversed pair not swapped");

  // settling restarts on any applied change into the gain stage
  settle_load_a: assert property (@(posedge core_clk) disable iff (!rstn)
    diff_apply_s |=>
      (s_r.settle == SETTLE_ADC_CYCLES))
    else $error("settling count not restarted");

  // one step down per converter clock while nothing new is applied
  settle_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
    adc_tick && (s_r.settle != 5'h00) && (s_r.sel == s_r.act) |=>
      (s_r.settle == 5'($past(s_r.settle) - 5'h01)))
    else $error("settling count did not step down");

  // zero wait states and an okay answer once out of reset
  ready_okay_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) |->
      hreadyout && (hresp == HRESP_OKAY))
    else $error("slave stalled or answered with an error");

endmodule : adc_input_mux_select

// File: test/tb.sv
// self-checking bench for the converter input and reference selection block
`timescale 1ns/1ps
module tb
  import adc_mux_pkg::*;
;
  // ************************************************************
  // bench signals and expected-value rows
  // ************************************************************
  typedef struct packed {
    logic [7:0] sel;     // value written to the selection register
    chan_kind_t kind;    // expected route kind
    logic [2:0] pos;     // expected positive or single input
    logic [2:0] neg;     // expected negative input
    logic g20;           // expected 20x gain
    logic temp;          // expected sensor enable
    logic [3:0] rr;      // expected reference route {code, int on, to pin}
  } row_t;
  localparam logic [31:0] SEL_ADDR = 32'({SEL_INDEX, 2'b00});   // byte address of selection
  localparam logic [31:0] ST_ADDR = 32'({STATUS_INDEX, 2'b00}); // byte address of status
  logic core_clk;          // bench clock, 40 ns
  logic rstn;              // synchronous reset, active low
  logic hsel;              // bus select
  logic [31:0] haddr;      // bus address
  logic [1:0] htrans;      // bus transfer type
  logic hwrite;            // bus direction
  logic [2:0] hsize;       // bus size, always word
  logic [31:0] hwdata;     // bus write data
  wire logic hready;       // bus ready, the one slave's hreadyout
  logic hreadyout;         // slave ready
  logic hresp;             // slave response
  logic [31:0] hrdata;     // slave read data
  logic conv_busy;         // conversion running
  logic conv_done;         // conversion-done pulse
  logic adc_tick;          // converter clock pulse
  chan_route_t chan_route; // active channel route
  ref_route_t ref_route;   // active reference route
  logic [31:0] rdv;        // last read data
  int num_errors;          // mismatches seen
  int samples_checked;     // comparisons made
  int tick_n [5] = '{0, 12, 1, 11, 1};                           // ticks before each status read
  logic [31:0] st_exp [5] = '{32'h6, 32'h6, 32'h2, 32'h2, 32'h0}; // status after those ticks
  // rows cover every reference code and each kind of channel code
  row_t rows [18] = '{
    '{8'h00, KIND_SINGLE, 3'd0, 3'd0, 1'b0, 1'b0, 4'h0}, '{8'h47, KIND_SINGLE, 3'd7, 3'd0, 1'b0, 1'b0, 4'h4},
    '{8'ha0, KIND_GROUND, 3'd0, 3'd0, 1'b0, 1'b0, 4'ha}, '{8'he1, KIND_BANDGAP, 3'd0, 3'd0, 1'b0, 1'b0, 4'hf},
    '{8'ha2, KIND_TEMP, 3'd0, 3'd0, 1'b0, 1'b1, 4'ha}, '{8'h08, KIND_DIFF, 3'd0, 3'd1, 1'b0, 1'b0, 4'h0},
    '{8'h09, KIND_DIFF, 3'd0, 3'd1, 1'b1, 1'b0, 4'h0}, '{8'h0b, KIND_DIFF, 3'd0, 3'd3, 1'b1, 1'b0, 4'h0},
    '{8'h1a, KIND_DIFF, 3'd4, 3'd5, 1'b0, 1'b0, 4'h0}, '{8'h1f, KIND_DIFF, 3'd6, 3'd7, 1'b1, 1'b0, 4'h0},
    '{8'h19, KIND_DIFF, 3'd3, 3'd7, 1'b1, 1'b0, 4'h0}, '{8'h28, KIND_DIFF, 3'd1, 3'd0, 1'b0, 1'b0, 4'h0},
    '{8'h3f, KIND_DIFF, 3'd7, 3'd6, 1'b1, 1'b0, 4'h0}, '{8'h30, KIND_DIFF, 3'd3, 3'd2, 1'b0, 1'b0, 4'h0},
    '{8'h36, KIND_DIFF, 3'd6, 3'd3, 1'b0, 1'b0, 4'h0}, '{8'h23, KIND_OFFSET_CAL, 3'd0, 3'd0, 1'b1, 1'b0, 4'h0},
    '{8'h24, KIND_OFFSET_CAL, 3'd3, 3'd3, 1'b0, 1'b0, 4'h0}, '{8'h27, KIND_OFFSET_CAL, 3'd7, 3'd7, 1'b1, 1'b0, 4'h0}};

  assign hready = hreadyout;

  adc_input_mux_select dut_u (.core_clk(core_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .conv_busy(conv_busy), .conv_done(conv_done), .adc_tick(adc_tick),
    .chan_route(chan_route), .ref_route(ref_route));

  // ************************************************************
  // clock
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ************************************************************
  // reporting and comparisons
  // ************************************************************
  // single place where the run ends
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // compare one bus word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk_word

  // compare both active routes at once
  task automatic chk_route(input chan_route_t exp_c, input logic [3:0] exp_r);
    samples_checked++;
    if ({chan_route, ref_route} !== {exp_c, exp_r})
    begin
      $display("unexpected at %0t: got %h expected %h", $time, {chan_route, ref_route}, {exp_c, exp_r});
      num_errors++;
    end
  endtask : chk_route

  // ************************************************************
  // bus and converter stimulus
  // ************************************************************
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (hready !== 1'b1 && n < 100);
    if (hready !== 1'b1)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, hready, 1'b1);
      num_errors++;
      end_of_test();
    end
  endtask : wait_ready

  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus

  // converter clock pulses, one every second system cycle
  task automatic tick(input int n);
    repeat (n)
    begin
      adc_tick <= 1'b1;
      @(posedge core_clk);
      adc_tick <= 1'b0;
      @(posedge core_clk);
    end
  endtask : tick

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    conv_busy = 1'b0;
    conv_done = 1'b0;
    adc_tick = 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk_route('0, 4'h0);
    bus(1'b0, SEL_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h0);
    chk_word({31'h0, hresp}, 32'h0);
    $display("test reset values done");
    // each row: write, read straight back, then check the applied routes
    foreach (rows[i])
    begin
      bus(1'b1, SEL_ADDR, {24'h0, rows[i].sel}, rdv);
      bus(1'b0, SEL_ADDR, 32'h0, rdv);
      chk_word(rdv, {24'h0, rows[i].sel});
      repeat (2) @(posedge core_clk);
      chk_route('{rows[i].kind, rows[i].pos, rows[i].neg, rows[i].g20, rows[i].temp}, rows[i].rr);
    end
    $display("test decode rows done");
    // writes during a conversion wait for its end, last write wins
    bus(1'b1, SEL_ADDR, 32'h00, rdv);
    @(posedge core_clk); // idle converter takes the new code first
    conv_busy <= 1'b1;
    @(posedge core_clk);
    bus(1'b1, SEL_ADDR, 32'h55, rdv);
    bus(1'b1, SEL_ADDR, 32'hea, rdv);
    repeat (4) @(posedge core_clk);
    bus(1'b0, ST_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h7);
    chk_route('{KIND_SINGLE, 3'd0, 3'd0, 1'b0, 1'b0}, 4'h0);
    conv_done <= 1'b1;
    @(posedge core_clk);
    conv_done <= 1'b0;
    conv_busy <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk_route('{KIND_DIFF, 3'd3, 3'd0, 1'b0, 1'b0}, 4'hf);
    $display("test held selection done");
    // settling window boundaries after a differential change
    foreach (tick_n[i])
    begin
      tick(tick_n[i]);
      bus(1'b0, ST_ADDR, 32'h0, rdv);
      chk_word(rdv, st_exp[i]);
    end
    bus(1'b1, SEL_ADDR, 32'h6a, rdv);
    repeat (3) @(posedge core_clk);
    bus(1'b0, ST_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h6);
    $display("test settling status done");
    // upper bits read zero, unmapped place ignored and reads zero
    bus(1'b1, SEL_ADDR, 32'hffffff12, rdv);
    bus(1'b1, 32'h40, 32'h3f, rdv);
    bus(1'b0, SEL_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h12);
    bus(1'b0, 32'h40, 32'h0, rdv);
    chk_word(rdv, 32'h0);
    $display("test unmapped access done");
    // second reset in mid-run clears the selection again
    bus(1'b1, SEL_ADDR, 32'ha2, rdv);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk_route('0, 4'h0);
    bus(1'b0, SEL_ADDR, 32'h0, rdv);
    chk_word(rdv, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb
